// *** inc/rtci_pkg.sv ***
// Function
// - summary flag high drives request pin low
// - periodic flag set on selected tap edge
// - periodic flag and enable raise request
// - alarm match sets flag, enable raises request
// - update end sets flag, enable raises request
// - flag register read clears three flags
// - flag register low nibble reads zero
// - battery bit high when either supply valid
// - battery register low seven bits zero
// - user ram always accessible, even updating
// - bank0 clock plus ram, bank1 extended ram
// - six enables, three per control register
// - enabling a set flag raises request immediately
// - events set flags regardless of enables
// - flags stable during read, events held
// - extended flags cleared only by writing zero
// - request held while any enabled flag set
// - oscillator pattern 01x runs, 11x resets chain
// - oscillator off after reset until enabled
// - enables at control bits 6,5,4, read/write
// - setting time-set inhibit clears update enable
// - lowest oscillator bit selects register bank
// - first update 500ms after running pattern
package rtci_pkg;
   // register offsets
   localparam logic [7:0] REG_RATE_CTRL = 8'h0a;
   localparam logic [7:0] REG_CONTROL = 8'h0b;
   localparam logic [7:0] REG_FLAGS = 8'h0c;
   localparam logic [7:0] REG_BATTERY = 8'h0d;
   localparam logic [7:0] REG_RAM_FIRST = 8'h0e;
   localparam logic [7:0] REG_BANK1_FIRST = 8'h40;
   localparam logic [7:0] REG_EXT_FLAGS = 8'h4a;
   localparam logic [7:0] REG_EXT_ENABLE = 8'h4b;
   localparam logic [7:0] REG_XRAM_ADDR_LO = 8'h50;
   localparam logic [7:0] REG_XRAM_ADDR_HI = 8'h51;
   localparam logic [7:0] REG_XRAM_DATA = 8'h53;
   // field positions
   localparam int BIT_SUMMARY = 7;
   localparam int BIT_PERIODIC = 6;
   localparam int BIT_ALARM = 5;
   localparam int BIT_UPDATE = 4;
   localparam int BIT_SET = 7;
   localparam int BIT_BATTERY = 7;
   localparam int BIT_BANK = 4;
   localparam int BIT_EXT_WAKE = 0;
   localparam int BIT_EXT_KICK = 1;
   localparam int BIT_EXT_RAMCLR = 2;
   // oscillator patterns on bits 6..5
   localparam logic [1:0] OSC_RUN = 2'h1;
   localparam logic [1:0] OSC_HOLD = 2'h3;
   // reset values
   localparam logic [7:0] RATE_CTRL_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // first update delay after the running pattern
   localparam int FIRST_UPDATE_MS = 500;
   localparam int SLOW_HZ = 32768;
   localparam int FIRST_UPDATE_TICKS = FIRST_UPDATE_MS * SLOW_HZ / 1000;
   localparam int TAP_COUNT = 16;
   // host bus phase
   typedef enum logic [1:0] {RTCI_IDLE, RTCI_READ, RTCI_WRITE} rtci_bus_e;
endpackage

// *** inc/rtci_ram_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// port to the user ram
interface rtci_ram_if #(parameter int AW = 13);
   logic wr_en;
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output wr_en, output addr, output wdata, input rdata);
   modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** src/rtci_ram.sv ***
`timescale 1ns/1ps
`default_nettype none
// user ram with registered read data
module rtci_ram #(
   parameter int AW = 13
) (
   // clock
   input wire logic clk,
   // access port
   rtci_ram_if.mem ram
);
   // storage array
   logic [7:0] mem_array [0:(1<<AW)-1];

   // write port
   always_ff @(posedge clk) begin
      if (ram.wr_en) begin
         mem_array[ram.addr] <= ram.wdata;
      end
   end

   // registered read
   always_ff @(posedge clk) begin
      ram.rdata <= mem_array[ram.addr];
   end
endmodule
`default_nettype wire

// *** src/rtci_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtci_core #(
   parameter int XRAM_AW = 13,
   parameter int FIRST_UPDATE = rtci_pkg::FIRST_UPDATE_TICKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // host bus with separate address and data lines, already in the clk domain
   input wire logic bus_sel,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   // slow timekeeping domain inputs (asynchronous)
   input wire logic [rtci_pkg::TAP_COUNT-1:0] divider_taps,
   input wire logic alarm_match,
   input wire logic update_done,
   input wire logic wake_event,
   input wire logic kick_event,
   input wire logic ramclr_event,
   // supply comparators (asynchronous)
   input wire logic backup_supply_main,
   input wire logic backup_supply_aux,
   // oscillator control
   output logic osc_enable,
   output logic chain_reset,
   output logic first_update_due,
   // interrupt request, active low
   output logic irq_n
);
   import rtci_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // synchronisers

   localparam int NSYNC = 9;
   logic [NSYNC-1:0] sync_a;  // first stage
   logic [NSYNC-1:0] sync_b;  // second stage
   logic [NSYNC-1:0] sync_c;  // edge history
   logic [NSYNC-1:0] async_in;
   logic tap_sel;  // selected divider tap
   logic [7:0] rate_ctrl;
   logic [3:0] rate_select;

   assign rate_select = rate_ctrl[3:0];
   assign tap_sel = divider_taps[rate_select];
   // bit 8 is the fixed fastest tap, counted for the first update whatever the rate
   assign async_in = {divider_taps[0], backup_supply_aux, backup_supply_main, ramclr_event, kick_event,
                      wake_event, update_done, alarm_match, tap_sel};

   // two flops then an edge stage per input
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
               sync_c[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= async_in[gi];
               sync_b[gi] <= sync_a[gi];
               sync_c[gi] <= sync_b[gi];
            end
         end
      end
   endgenerate

   // rising edges of the synchronised events
   logic ev_periodic, ev_alarm, ev_update, ev_wake, ev_kick, ev_ramclr;
   assign ev_periodic = sync_b[0] & ~sync_c[0] & (rate_select != 4'h0);
   assign ev_alarm = sync_b[1] & ~sync_c[1];
   assign ev_update = sync_b[2] & ~sync_c[2];
   assign ev_wake = sync_b[3] & ~sync_c[3];
   assign ev_kick = sync_b[4] & ~sync_c[4];
   assign ev_ramclr = sync_b[5] & ~sync_c[5];

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   logic bank1;  // bank select
   logic rd_req, wr_req;
   logic rd_flags;  // read of the flag register this cycle
   logic rd_flags_d;  // read in progress last cycle
   logic read_end;  // flag read completes
   logic is_ram, is_xram_data;

   assign bank1 = rate_ctrl[BIT_BANK];
   assign rd_req = bus_sel & bus_rd;
   assign wr_req = bus_sel & bus_wr;
   assign rd_flags = rd_req & (bus_addr == REG_FLAGS);
   assign read_end = rd_flags_d & ~rd_flags;
   assign is_ram = (bus_addr >= REG_RAM_FIRST) & (bus_addr[7] == 1'b0)
                   & ~(bank1 & (bus_addr >= REG_BANK1_FIRST));
   assign is_xram_data = bank1 & (bus_addr == REG_XRAM_DATA);

   // track read of the flag register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_flags_d <= 1'b0;
      end else begin
         rd_flags_d <= rd_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers

   logic [7:0] control;
   logic [2:0] ext_enable;
   logic [XRAM_AW-1:0] xram_addr;

   // rate / oscillator register, oscillator off from reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rate_ctrl <= RATE_CTRL_RESET;
      end else if (wr_req && bus_addr == REG_RATE_CTRL) begin
         rate_ctrl <= {1'b0, bus_wdata[6:0]};
      end
   end

   // control register with enables
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         control <= CONTROL_RESET;
      end else if (wr_req && bus_addr == REG_CONTROL) begin
         control <= bus_wdata;
         if (bus_wdata[BIT_SET]) begin
            control[BIT_UPDATE] <= 1'b0;
         end
      end
   end

   // extended enables, bank 1 only
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_enable <= 3'h0;
      end else if (wr_req && bank1 && bus_addr == REG_EXT_ENABLE) begin
         ext_enable <= bus_wdata[2:0];
      end
   end

   // extended ram address, set only by host writes, not changed by data access
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         xram_addr <= '0;
      end else if (wr_req && bank1 && bus_addr == REG_XRAM_ADDR_LO) begin
         xram_addr[7:0] <= bus_wdata;
      end else if (wr_req && bank1 && bus_addr == REG_XRAM_ADDR_HI) begin
         xram_addr[XRAM_AW-1:8] <= bus_wdata[XRAM_AW-9:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // oscillator control and first update

   logic [31:0] first_cnt;
   logic running;
   logic running_d;
   logic ev_slow_tick;  // either edge of the fixed tap, independent of the rate select

   assign ev_slow_tick = sync_b[8] ^ sync_c[8];

   assign running = (rate_ctrl[6:5] == OSC_RUN);
   assign osc_enable = running | (rate_ctrl[6:5] == OSC_HOLD);
   assign chain_reset = ~running;

   // count slow ticks until first update
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         running_d <= 1'b0;
         first_cnt <= '0;
         first_update_due <= 1'b0;
      end else begin
         running_d <= running;
         first_update_due <= 1'b0;
         if (running && !running_d) begin
            first_cnt <= 32'(FIRST_UPDATE);
         end else if (first_cnt != '0 && ev_slow_tick) begin
            first_cnt <= first_cnt - 32'h1;
            first_update_due <= (first_cnt == 32'h1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags

   logic [2:0] flags;  // periodic, alarm, update
   logic [2:0] pend;  // events held during a read
   logic [2:0] ev_main;
   logic [2:0] ext_flags;  // wake, kick, ram clear
   logic [2:0] ev_ext;
   logic [2:0] enables;
   logic summary;

   assign ev_main = {ev_periodic, ev_alarm, ev_update};
   assign ev_ext = {ev_ramclr, ev_kick, ev_wake};
   assign enables = control[6:4];

   // read-to-clear flags with hold during the read
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flags <= 3'h0;
         pend <= 3'h0;
      end else if (rd_flags) begin
         pend <= pend | ev_main;
      end else if (read_end) begin
         flags <= pend | ev_main;
         pend <= 3'h0;
      end else begin
         flags <= flags | pend | ev_main;
         pend <= 3'h0;
      end
   end

   // extended flags, cleared by writing zero, set wins
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_flags <= 3'h0;
      end else if (wr_req && bank1 && bus_addr == REG_EXT_FLAGS) begin
         ext_flags <= (ext_flags & bus_wdata[2:0]) | ev_ext;
      end else begin
         ext_flags <= ext_flags | ev_ext;
      end
   end

   // summary from enabled flags, combinational so enabling acts at once
   assign summary = |(flags & enables) | |(ext_flags & ext_enable);
   assign irq_n = ~summary;

   ////////////////////////////////////////////////////////////////////////
   // user ram

   rtci_ram_if #(.AW(XRAM_AW)) ram_bus ();
   logic [7:0] reg_rdata;

   assign ram_bus.addr = is_xram_data ? xram_addr : XRAM_AW'(bus_addr);
   assign ram_bus.wdata = bus_wdata;
   assign ram_bus.wr_en = wr_req & (is_ram | is_xram_data);

   rtci_ram #(.AW(XRAM_AW)) u_ram (
      .clk(clk),
      .ram(ram_bus)
   );

   ////////////////////////////////////////////////////////////////////////
   // read mux

   logic use_ram;

   // register read data, captured while the read is active
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= ZERO_BYTE;
         use_ram <= 1'b0;
      end else if (rd_req) begin
         use_ram <= is_ram | is_xram_data;
         case (bus_addr)
            REG_RATE_CTRL: reg_rdata <= rate_ctrl;
            REG_CONTROL: reg_rdata <= control;
            REG_FLAGS: begin
               if (!rd_flags_d) begin
                  reg_rdata <= {summary, flags, 4'h0};
               end
            end
            REG_BATTERY: reg_rdata <= {sync_b[6] | sync_b[7], 7'h00};
            REG_EXT_FLAGS: reg_rdata <= bank1 ? {5'h00, ext_flags} : ZERO_BYTE;
            REG_EXT_ENABLE: reg_rdata <= bank1 ? {5'h00, ext_enable} : ZERO_BYTE;
            default: reg_rdata <= ZERO_BYTE;
         endcase
      end
   end

   assign bus_rdata = use_ram ? ram_bus.rdata : reg_rdata;
endmodule
`default_nettype wire

// *** verification/rtci_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// port-level checks of flags, status and oscillator control
module rtci_chk
   import rtci_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // host bus
   input wire logic bus_sel,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   // supplies and outputs
   input wire logic backup_supply_main,
   input wire logic backup_supply_aux,
   input wire logic osc_enable,
   input wire logic chain_reset,
   input wire logic first_update_due,
   input wire logic irq_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic rd_c; // read of the flag register
   logic rd_d; // read of the battery register
   logic wr_a; // write of the rate register
   assign rd_c = bus_sel && bus_rd && bus_addr == REG_FLAGS;
   assign rd_d = bus_sel && bus_rd && bus_addr == REG_BATTERY;
   assign wr_a = bus_sel && bus_wr && bus_addr == REG_RATE_CTRL;
   ////////////////////////////////////////////////////////////
   a_flag_low_zero: assert property ($rose(rd_c) |=> bus_rdata[3:0] == 4'h0)
      else $error("flag low nibble not zero");
   a_summary_irq: assert property ($rose(rd_c) |=> bus_rdata[7] == !$past(irq_n))
      else $error("summary flag differs from request pin");
   a_batt_status: assert property ($rose(rd_d) |=>
      bus_rdata == {backup_supply_main || backup_supply_aux, 7'h00})
      else $error("battery register wrong");
   a_osc_run: assert property (wr_a && bus_wdata[6:5] == OSC_RUN |=> osc_enable && !chain_reset)
      else $error("run pattern not obeyed");
   a_osc_hold: assert property (wr_a && bus_wdata[6:5] == OSC_HOLD |=> osc_enable && chain_reset)
      else $error("hold pattern not obeyed");
   a_osc_off: assert property (wr_a && !bus_wdata[5] |=> !osc_enable)
      else $error("oscillator not stopped");
   a_irq_release: assert property ($rose(irq_n) |->
      $past(bus_sel) || $past(bus_sel, 2) || $past(bus_sel, 3))
      else $error("request released without host access");
   a_update_pulse: assert property (first_update_due |=> !first_update_due)
      else $error("first update not a single pulse");
endmodule
bind rtci_core rtci_chk chk (.clk, .sys_rst, .bus_sel, .bus_rd, .bus_wr, .bus_addr, .bus_wdata, .bus_rdata,
   .backup_supply_main, .backup_supply_aux, .osc_enable, .chain_reset, .first_update_due, .irq_n);
`default_nettype wire

// *** verification/rtci_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// host processor model driving the byte-wide bus
module rtci_host (
   // clock
   input wire logic clk,
   // bus toward the device
   output logic bus_sel,
   output logic bus_rd,
   output logic bus_wr,
   output logic [7:0] bus_addr,
   output logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata
);
   // idle bus, address and data driven to zero
   initial begin
      bus_sel = 1'b0;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
   end
   // one write: held over one taking edge, then released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_sel <= 1'b1;
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_sel <= 1'b0;
      bus_wr <= 1'b0;
      bus_addr <= ~a;
      bus_wdata <= ~d;
   endtask
   // one read: data taken at the edge after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_sel <= 1'b1;
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      @(posedge clk);
      d = bus_rdata;
      bus_sel <= 1'b0;
      bus_rd <= 1'b0;
      bus_addr <= ~a;
   endtask
endmodule
`default_nettype wire

// *** verification/rtci_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h",n,e,g); end end
module rtci_core_tb;
   import rtci_pkg::*;
   logic clk, sys_rst, bus_sel, bus_rd, bus_wr, osc_enable, chain_reset, first_update_due, irq_n;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, d, d2;
   logic [15:0] divider_taps;
   logic alarm_match, update_done, wake_event, kick_event, ramclr_event, backup_supply_main, backup_supply_aux;
   logic [7:0] ram_a [4] = '{8'h0e, 8'h3f, 8'h40, 8'h7f}; // user ram corners
   int num_errors = 0, checked = 0, pulses = 0, i;
   rtci_core #(.XRAM_AW(13), .FIRST_UPDATE(4)) dut (.clk, .sys_rst, .bus_sel, .bus_rd, .bus_wr, .bus_addr,
      .bus_wdata, .bus_rdata, .divider_taps, .alarm_match, .update_done, .wake_event, .kick_event, .ramclr_event,
      .backup_supply_main, .backup_supply_aux, .osc_enable, .chain_reset, .first_update_due, .irq_n);
   rtci_host host (.clk, .bus_sel, .bus_rd, .bus_wr, .bus_addr, .bus_wdata, .bus_rdata);
   ////////////////////////////////////////////////////////////
   // clock, pulse count and watchdog
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) if (first_update_due === 1'b1) pulses <= pulses + 1;
   initial begin
      #100000;
      num_errors++;
      conclude();
   end
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic conclude();
      if (num_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      divider_taps = 16'h0000;
      {alarm_match, update_done, wake_event, kick_event, ramclr_event, backup_supply_aux} = 6'h00;
      backup_supply_main = 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      w(1);
      `CHK("osc", 1'b0, osc_enable)
      // status registers refuse writes
      host.wr(REG_FLAGS, 8'hff);
      host.wr(REG_BATTERY, 8'hff);
      host.rd(REG_FLAGS, d);
      `CHK("flags", 8'h00, d)
      for (i = 0; i < 3; i++) begin
         host.rd(REG_BATTERY, d);
         `CHK("battery", i == 1 ? 8'h00 : 8'h80, d)
         @(posedge clk);
         {backup_supply_aux, backup_supply_main} <= i == 0 ? 2'h0 : 2'h2;
         w(4);
      end
      // every oscillator pattern
      for (i = 0; i < 8; i++) begin
         host.wr(REG_RATE_CTRL, 8'(i << 4));
         #1;
         `CHK("osc", logic'(i[1]), osc_enable)
         if (i[1]) `CHK("chain", logic'(i[2]), chain_reset)
      end
      host.wr(REG_RATE_CTRL, 8'h21);
      pulses = 0;
      for (i = 0; i < 12; i++) begin
         @(posedge clk) divider_taps[0] <= !divider_taps[0];
         w(3);
      end
      `CHK("first_update", 1, pulses)
      // periodic flag polled with its enable off
      @(posedge clk) divider_taps[1] <= 1'b1;
      w(6);
      `CHK("irq", 1'b1, irq_n)
      host.rd(REG_FLAGS, d);
      `CHK("flags", 8'h40, d)
      host.rd(REG_FLAGS, d);
      `CHK("flags", 8'h00, d)
      // alarm flag pending, then enabled
      @(posedge clk) alarm_match <= 1'b1;
      w(6);
      host.wr(REG_CONTROL, 8'h60);
      #1;
      `CHK("irq", 1'b0, irq_n)
      host.rd(REG_FLAGS, d);
      `CHK("flags", 8'ha0, d)
      w(3);
      `CHK("irq", 1'b1, irq_n)
      host.rd(REG_CONTROL, d);
      `CHK("control", 8'h60, d)
      // periodic with enable, stale flags already cleared
      @(posedge clk) divider_taps[1] <= 1'b0;
      w(6);
      host.rd(REG_FLAGS, d);
      @(posedge clk) divider_taps[1] <= 1'b1;
      w(6);
      `CHK("irq", 1'b0, irq_n)
      host.rd(REG_FLAGS, d);
      `CHK("flags", 8'hc0, d)
      // time-set inhibit drops update enable
      host.wr(REG_CONTROL, 8'h10);
      host.wr(REG_CONTROL, 8'h90);
      host.rd(REG_CONTROL, d);
      `CHK("control", 8'h80, d)
      // update event landing during a flag read is kept once
      @(posedge clk) update_done <= 1'b1;
      host.rd(REG_FLAGS, d);
      host.rd(REG_FLAGS, d2);
      `CHK("held", 16'h1000, {d | d2, d & d2})
      // bank 1: extended flags, enables and ram
      host.wr(REG_RATE_CTRL, 8'h30);
      @(posedge clk);
      {wake_event, kick_event, ramclr_event} <= 3'h7;
      w(6);
      for (i = 0; i < 2; i++) begin
         host.rd(REG_EXT_FLAGS, d);
         `CHK("ext_flags", 8'h07, d)
      end
      host.wr(REG_EXT_ENABLE, 8'h02);
      #1;
      `CHK("irq", 1'b0, irq_n)
      host.wr(REG_EXT_FLAGS, 8'h05);
      #1;
      `CHK("irq", 1'b1, irq_n)
      host.rd(REG_EXT_FLAGS, d);
      `CHK("ext_flags", 8'h05, d)
      host.wr(8'h52, 8'hff);
      host.rd(8'h52, d);
      `CHK("unmapped", 8'h00, d)
      host.wr(REG_XRAM_ADDR_LO, 8'h34);
      host.wr(REG_XRAM_ADDR_HI, 8'h12);
      host.wr(REG_XRAM_DATA, 8'ha5);
      host.wr(REG_XRAM_ADDR_LO, 8'h34);
      host.rd(REG_XRAM_DATA, d);
      `CHK("xram", 8'ha5, d)
      // bank 0: the four corner bytes of the 114 user bytes reach ram
      host.wr(REG_RATE_CTRL, 8'h20);
      for (i = 0; i < 4; i++) host.wr(ram_a[i], ~ram_a[i]);
      for (i = 0; i < 4; i++) begin
         host.rd(ram_a[i], d);
         `CHK("ram", ~ram_a[i], d)
      end
      conclude();
   end
endmodule
`default_nettype wire
